// ### src/mfcu_core.v
// mfcu_core.v: executor for multiply and program-flow operations; owns the pc and status_register
// assumes: a decoder presents one operation with its operands while READY is high; stack unit
// supplies the top return address with every operation and honours push/pop strobes
//
// Contract
// [RULE_01] plain, signed and mixed multiplies write 16-bit product; 2 cycles; only Z,C change
// [RULE_02] fractional multiplies shift the product left one bit; 2 cycles; only Z,C change
// [RULE_03] relative jump pc+k+1, pointer jump Z, both 2 cycles; absolute 3; flags kept
// [RULE_04] invokes: relative and pointer 3 cycles, absolute 4; return address pushed
// [RULE_05] return pops pc in 4 cycles; interrupt exit also sets interrupt enable
// [RULE_06] compare-skip-equal skips next on match; 1, 2 or 3 cycles; flags kept
// [RULE_07] compares subtract without storing; update Z,N,V,C,H in one cycle
// [RULE_08] register-bit skips test chosen bit, skip on clear or set; 1/2/3 cycles
// [RULE_09] io-bit skips test chosen io bit, skip on clear or set; 1/2/3 cycles
// [RULE_10] status-bit branch tests selected flag; taken pc+k+1 in 2, else 1 cycle
// [RULE_11] carry branches: same-or-higher on C clear, lower on C set; 1/2 cycles
// [RULE_12] signed greater-equal taken on N xor V zero, less-than on one; 1/2 cycles
// [RULE_13] half-carry branches taken on H set or clear; 1 cycle untaken, 2 taken
// [RULE_14] transfer-bit branches taken on T set or clear; 1/2 cycles, flags kept
`timescale 1ns/100ps
`include "mfcu_defines.vh"

module mfcu_core #(
  parameter PCW = 16
) (
  // clock and reset
  input  wire           MCLK,
  input  wire           RSTN,
  // operation issue
  input  wire           ISSUE,
  input  wire [4:0]     OP,
  input  wire [7:0]     RD_VAL,
  input  wire [7:0]     RR_VAL,
  input  wire [2:0]     BIT_SEL,
  input  wire [7:0]     IO_VAL,
  input  wire [11:0]    OFFSET,
  input  wire [PCW-1:0] TARGET,
  input  wire [PCW-1:0] Z_PTR,
  input  wire           NEXT_TWO_WORD,
  input  wire [PCW-1:0] STACK_TOP,
  output reg            READY,
  // completion
  output reg            DONE,
  output reg  [2:0]     CYCLES,
  output reg  [PCW-1:0] PC,
  output reg  [7:0]     STATUS,
  // product_result_pair
  output reg  [15:0]    PRODUCT,
  output reg            PRODUCT_WE,
  // stack strobes
  output reg            PUSH_VALID,
  output reg  [PCW-1:0] PUSH_ADDR,
  output reg            POP_VALID
);
  localparam [PCW-1:0] ONE = {{(PCW-1){1'b0}}, 1'b1};
  localparam [PCW-1:0] TWO = {{(PCW-2){1'b0}}, 2'b10};

  // pc plus sign-extended displacement plus one
  function [PCW-1:0] rel_target;
    input [PCW-1:0] base;
    input [11:0]    off;
    begin
      rel_target = base + {{(PCW-12){off[11]}}, off} + ONE;
    end
  endfunction

  reg  [2:0]     cnt;
  reg  [PCW-1:0] pend_pc;
  reg  [7:0]     pend_status;
  reg  [15:0]    pend_product;
  reg            pend_prod_we;
  reg            pend_push;
  reg  [PCW-1:0] pend_push_addr;
  reg            pend_pop;
  reg  [2:0]     pend_cyc;

  reg  [PCW-1:0] next_pc;
  reg  [7:0]     next_status;
  reg  [2:0]     next_cyc;
  reg            next_prod_we;
  reg            next_push;
  reg  [PCW-1:0] next_push_addr;
  reg            next_pop;
  reg            skip;
  reg  [2:0]     next_cnt;

  wire           accept;
  wire           commit;
  wire [PCW-1:0] cur_pc;
  wire [7:0]     cur_status;
  wire [PCW-1:0] seq_pc;
  wire [PCW-1:0] skip_pc;
  wire [2:0]     skip_cyc;
  wire [15:0]    mul_product;
  wire           mul_carry;
  wire           mul_zero;
  wire           mul_a_signed;
  wire           mul_b_signed;
  wire           mul_fraction;
  wire           cmp_borrow_in;
  wire [8:0]     cmp_diff;
  wire [7:0]     cmp_res;

  assign accept = ISSUE & READY;
  assign commit = (cnt == `MFCU_CYC_ONE);
  // forward the finishing operation so an operation issued on the same edge sees its results
  assign cur_pc     = commit ? pend_pc : PC;
  assign cur_status = commit ? pend_status : STATUS;
  assign seq_pc     = cur_pc + ONE;
  // a skipped two-word operation costs an extra word and an extra cycle
  assign skip_pc  = NEXT_TWO_WORD ? cur_pc + TWO + ONE : cur_pc + TWO;
  assign skip_cyc = NEXT_TWO_WORD ? `MFCU_CYC_THREE : `MFCU_CYC_TWO;

  assign mul_a_signed = (OP == `MFCU_OP_PRODUCT_SIGNED) | (OP == `MFCU_OP_PRODUCT_SIGNED_BY_UNSIGNED) |
                        (OP == `MFCU_OP_FRACTION_PRODUCT_SIGNED) | (OP == `MFCU_OP_FRACTION_PRODUCT_MIXED);
  assign mul_b_signed = (OP == `MFCU_OP_PRODUCT_SIGNED) | (OP == `MFCU_OP_FRACTION_PRODUCT_SIGNED);
  assign mul_fraction = (OP == `MFCU_OP_FRACTION_PRODUCT_UNSIGNED) | (OP == `MFCU_OP_FRACTION_PRODUCT_SIGNED) |
                        (OP == `MFCU_OP_FRACTION_PRODUCT_MIXED);

  mfcu_mult u_mult (
    .a        (RD_VAL),
    .b        (RR_VAL),
    .a_signed (mul_a_signed),
    .b_signed (mul_b_signed),
    .fraction (mul_fraction),
    .product  (mul_product),
    .carry    (mul_carry),
    .zero     (mul_zero)
  );

  assign cmp_borrow_in = (OP == `MFCU_OP_COMPARE_WITH_BORROW) & cur_status[`MFCU_FLAG_C];
  assign cmp_diff      = {1'b0, RD_VAL} - {1'b0, RR_VAL} - {8'h00, cmp_borrow_in};
  assign cmp_res       = cmp_diff[7:0];

  always @* begin
    next_pc        = seq_pc;
    next_status    = cur_status;
    next_cyc       = `MFCU_CYC_ONE;
    next_prod_we   = 1'b0;
    next_push      = 1'b0;
    next_push_addr = seq_pc;
    next_pop       = 1'b0;
    skip           = 1'b0;
    case (OP)
      `MFCU_OP_PRODUCT_UNSIGNED, `MFCU_OP_PRODUCT_SIGNED, `MFCU_OP_PRODUCT_SIGNED_BY_UNSIGNED,
      `MFCU_OP_FRACTION_PRODUCT_UNSIGNED, `MFCU_OP_FRACTION_PRODUCT_SIGNED,
      `MFCU_OP_FRACTION_PRODUCT_MIXED: begin
        next_cyc                  = `MFCU_CYC_TWO;     // [RULE_01] [RULE_02]
        next_prod_we              = 1'b1;              // [RULE_01] [RULE_02]
        next_status[`MFCU_FLAG_C] = mul_carry;         // [RULE_01] [RULE_02]
        next_status[`MFCU_FLAG_Z] = mul_zero;          // [RULE_01] [RULE_02]
      end
      `MFCU_OP_RELATIVE_JUMP: begin
        next_pc  = rel_target(cur_pc, OFFSET);         // [RULE_03]
        next_cyc = `MFCU_CYC_TWO;                      // [RULE_03]
      end
      `MFCU_OP_POINTER_JUMP: begin
        next_pc  = Z_PTR;                              // [RULE_03]
        next_cyc = `MFCU_CYC_TWO;                      // [RULE_03]
      end
      `MFCU_OP_ABSOLUTE_JUMP: begin
        next_pc  = TARGET;                             // [RULE_03]
        next_cyc = `MFCU_CYC_THREE;                    // [RULE_03]
      end
      `MFCU_OP_RELATIVE_INVOKE: begin
        next_pc   = rel_target(cur_pc, OFFSET);        // [RULE_04]
        next_cyc  = `MFCU_CYC_THREE;                   // [RULE_04]
        next_push = 1'b1;                              // [RULE_04]
      end
      `MFCU_OP_POINTER_INVOKE: begin
        next_pc   = Z_PTR;                             // [RULE_04]
        next_cyc  = `MFCU_CYC_THREE;                   // [RULE_04]
        next_push = 1'b1;                              // [RULE_04]
      end
      `MFCU_OP_ABSOLUTE_INVOKE: begin
        // two-word operation: return lands after the address word
        next_pc        = TARGET;                       // [RULE_04]
        next_cyc       = `MFCU_CYC_FOUR;               // [RULE_04]
        next_push      = 1'b1;                         // [RULE_04]
        next_push_addr = cur_pc + TWO;                 // [RULE_04]
      end
      `MFCU_OP_POP_PROGRAM_COUNTER, `MFCU_OP_INTERRUPT_EXIT_POP: begin
        next_pc  = STACK_TOP;                          // [RULE_05]
        next_cyc = `MFCU_CYC_FOUR;                     // [RULE_05]
        next_pop = 1'b1;                               // [RULE_05]
        if (OP == `MFCU_OP_INTERRUPT_EXIT_POP) begin
          next_status[`MFCU_FLAG_I] = 1'b1;            // [RULE_05]
        end
      end
      `MFCU_OP_COMPARE_SKIP_EQUAL: skip = (RD_VAL == RR_VAL);                // [RULE_06]
      `MFCU_OP_COMPARE_REGS, `MFCU_OP_COMPARE_WITH_BORROW, `MFCU_OP_COMPARE_IMMEDIATE: begin
        // borrow chain keeps Z only while every byte so far was zero
        next_status[`MFCU_FLAG_Z] = (cmp_res == 8'h00) &
          ((OP != `MFCU_OP_COMPARE_WITH_BORROW) | cur_status[`MFCU_FLAG_Z]);  // [RULE_07]
        next_status[`MFCU_FLAG_N] = cmp_res[7];                                // [RULE_07]
        next_status[`MFCU_FLAG_V] = (RD_VAL[7] & ~RR_VAL[7] & ~cmp_res[7]) |
                                    (~RD_VAL[7] & RR_VAL[7] & cmp_res[7]);     // [RULE_07]
        next_status[`MFCU_FLAG_C] = (~RD_VAL[7] & RR_VAL[7]) | (RR_VAL[7] & cmp_res[7]) |
                                    (cmp_res[7] & ~RD_VAL[7]);                 // [RULE_07]
        next_status[`MFCU_FLAG_H] = (~RD_VAL[3] & RR_VAL[3]) | (RR_VAL[3] & cmp_res[3]) |
                                    (cmp_res[3] & ~RD_VAL[3]);                 // [RULE_07]
      end
      `MFCU_OP_SKIP_REGISTER_BIT_CLEAR: skip = ~RR_VAL[BIT_SEL];             // [RULE_08]
      `MFCU_OP_SKIP_REGISTER_BIT_SET:   skip = RR_VAL[BIT_SEL];              // [RULE_08]
      `MFCU_OP_SKIP_IO_BIT_CLEAR:       skip = ~IO_VAL[BIT_SEL];             // [RULE_09]
      `MFCU_OP_SKIP_IO_BIT_SET:         skip = IO_VAL[BIT_SEL];              // [RULE_09]
      `MFCU_OP_BRANCH_STATUS_BIT_SET, `MFCU_OP_BRANCH_STATUS_BIT_CLEAR: begin
        // carry, signed (S = N xor V), half-carry and transfer forms are all selects of one flag
        if (cur_status[BIT_SEL] == (OP == `MFCU_OP_BRANCH_STATUS_BIT_SET)) begin // [RULE_10] [RULE_11] [RULE_13] [RULE_14]
          next_pc  = rel_target(cur_pc, OFFSET);       // [RULE_10]
          next_cyc = `MFCU_CYC_TWO;                    // [RULE_10]
        end
      end
      default: next_pc = seq_pc;
    endcase
    if (skip) begin
      next_pc  = skip_pc;                              // [RULE_06] [RULE_08] [RULE_09]
      next_cyc = skip_cyc;                             // [RULE_06] [RULE_08] [RULE_09]
    end
    // S is kept as N xor V so signed branches select it directly
    next_status[`MFCU_FLAG_S] = next_status[`MFCU_FLAG_N] ^ next_status[`MFCU_FLAG_V]; // [RULE_12]
    if ((OP == `MFCU_OP_PRODUCT_UNSIGNED) || (OP == `MFCU_OP_PRODUCT_SIGNED) ||
        (OP == `MFCU_OP_PRODUCT_SIGNED_BY_UNSIGNED) || (OP == `MFCU_OP_FRACTION_PRODUCT_UNSIGNED) ||
        (OP == `MFCU_OP_FRACTION_PRODUCT_SIGNED) || (OP == `MFCU_OP_FRACTION_PRODUCT_MIXED)) begin
      next_status[`MFCU_FLAG_S] = cur_status[`MFCU_FLAG_S]; // [RULE_01] [RULE_02]
    end
  end

  always @* begin
    if (accept) begin
      next_cnt = next_cyc;
    end else if (cnt != 3'h0) begin
      next_cnt = cnt - 3'h1;
    end else begin
      next_cnt = 3'h0;
    end
  end

  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      cnt            <= 3'h0;
      READY          <= 1'b1;
      DONE           <= 1'b0;
      CYCLES         <= 3'h0;
      PC             <= `MFCU_RST_PC;
      STATUS         <= `MFCU_RST_STATUS;
      PRODUCT        <= 16'h0000;
      PRODUCT_WE     <= 1'b0;
      PUSH_VALID     <= 1'b0;
      PUSH_ADDR      <= `MFCU_RST_PC;
      POP_VALID      <= 1'b0;
      pend_pc        <= `MFCU_RST_PC;
      pend_status    <= `MFCU_RST_STATUS;
      pend_product   <= 16'h0000;
      pend_prod_we   <= 1'b0;
      pend_push      <= 1'b0;
      pend_push_addr <= `MFCU_RST_PC;
      pend_pop       <= 1'b0;
      pend_cyc       <= 3'h0;
    end else begin
      cnt        <= next_cnt;
      // ready in the last cycle lets a new operation overlap the commit of the old one
      READY      <= (next_cnt <= `MFCU_CYC_ONE);
      DONE       <= commit;
      PRODUCT_WE <= commit & pend_prod_we;
      PUSH_VALID <= commit & pend_push;
      POP_VALID  <= commit & pend_pop;
      if (commit) begin
        PC        <= pend_pc;
        STATUS    <= pend_status;
        CYCLES    <= pend_cyc;
        PUSH_ADDR <= pend_push_addr;
        if (pend_prod_we) begin
          PRODUCT <= pend_product;                     // [RULE_01] [RULE_02]
        end
      end
      if (accept) begin
        pend_pc        <= next_pc;
        pend_status    <= next_status;
        pend_product   <= mul_product;
        pend_prod_we   <= next_prod_we;
        pend_push      <= next_push;
        pend_push_addr <= next_push_addr;
        pend_pop       <= next_pop;
        pend_cyc       <= next_cyc;
      end
    end
  end
endmodule // mfcu_core

// ### pkg/mfcu_defines.vh
// mfcu_defines.vh: operation codes, status flag positions, cycle counts and reset values
// assumes: included by the multiply/flow-control executor sources and by the bench
`ifndef MFCU_DEFINES_VH
`define MFCU_DEFINES_VH

// operation codes presented by the instruction decoder
`define MFCU_OP_PRODUCT_UNSIGNED           5'h00
`define MFCU_OP_PRODUCT_SIGNED             5'h01
`define MFCU_OP_PRODUCT_SIGNED_BY_UNSIGNED 5'h02
`define MFCU_OP_FRACTION_PRODUCT_UNSIGNED  5'h03
`define MFCU_OP_FRACTION_PRODUCT_SIGNED    5'h04
`define MFCU_OP_FRACTION_PRODUCT_MIXED     5'h05
`define MFCU_OP_RELATIVE_JUMP              5'h06
`define MFCU_OP_POINTER_JUMP               5'h07
`define MFCU_OP_ABSOLUTE_JUMP              5'h08
`define MFCU_OP_RELATIVE_INVOKE            5'h09
`define MFCU_OP_POINTER_INVOKE             5'h0a
`define MFCU_OP_ABSOLUTE_INVOKE            5'h0b
`define MFCU_OP_POP_PROGRAM_COUNTER        5'h0c
`define MFCU_OP_INTERRUPT_EXIT_POP         5'h0d
`define MFCU_OP_COMPARE_SKIP_EQUAL         5'h0e
`define MFCU_OP_COMPARE_REGS               5'h0f
`define MFCU_OP_COMPARE_WITH_BORROW        5'h10
`define MFCU_OP_COMPARE_IMMEDIATE          5'h11
`define MFCU_OP_SKIP_REGISTER_BIT_CLEAR    5'h12
`define MFCU_OP_SKIP_REGISTER_BIT_SET      5'h13
`define MFCU_OP_SKIP_IO_BIT_CLEAR          5'h14
`define MFCU_OP_SKIP_IO_BIT_SET            5'h15
`define MFCU_OP_BRANCH_STATUS_BIT_SET      5'h16
`define MFCU_OP_BRANCH_STATUS_BIT_CLEAR    5'h17
`define MFCU_OP_ADVANCE                    5'h18

// status_register bit positions; named branches are the two status-bit forms with these selects
`define MFCU_FLAG_C 3'h0
`define MFCU_FLAG_Z 3'h1
`define MFCU_FLAG_N 3'h2
`define MFCU_FLAG_V 3'h3
`define MFCU_FLAG_S 3'h4
`define MFCU_FLAG_H 3'h5
`define MFCU_FLAG_T 3'h6
`define MFCU_FLAG_I 3'h7

// cycle counts
`define MFCU_CYC_ONE   3'h1
`define MFCU_CYC_TWO   3'h2
`define MFCU_CYC_THREE 3'h3
`define MFCU_CYC_FOUR  3'h4

// reset values
`define MFCU_RST_PC     16'h0000
`define MFCU_RST_STATUS 8'h00

`endif

// ### src/mfcu_mult.v
// mfcu_mult.v: combinational 8x8 multiplier for the plain and fractional product forms
// assumes: operands are stable for the cycle the executor samples the result
`timescale 1ns/100ps
`include "mfcu_defines.vh"

module mfcu_mult (
  // operands
  input  wire [7:0]  a,
  input  wire [7:0]  b,
  input  wire        a_signed,
  input  wire        b_signed,
  input  wire        fraction,
  // result
  output wire [15:0] product,
  output wire        carry,
  output wire        zero
);
  wire signed [8:0]  ext_a;
  wire signed [8:0]  ext_b;
  wire signed [17:0] full;
  wire        [15:0] raw;

  assign ext_a   = {a_signed & a[7], a};
  assign ext_b   = {b_signed & b[7], b};
  assign full    = ext_a * ext_b;
  assign raw     = full[15:0];
  // carry is taken from the unshifted product so the lost top bit is kept visible
  assign carry   = raw[15];
  assign product = fraction ? {raw[14:0], 1'b0} : raw;
  assign zero    = (product == 16'h0000);
endmodule // mfcu_mult

// ### sim/mfcu_core_sva.sv
// mfcu_core_sva.sv: port-level checks for the multiply and program-flow executor
// assumes: bound to mfcu_core; single clock MCLK, asynchronous active-low RSTN
`timescale 1ns/100ps

module mfcu_core_sva (
  // clock and reset
  input wire        MCLK,
  input wire        RSTN,
  // issue and completion
  input wire        READY,
  input wire        DONE,
  input wire [2:0]  CYCLES,
  input wire [7:0]  STATUS,
  // product and stack strobes
  input wire [15:0] PRODUCT,
  input wire        PRODUCT_WE,
  input wire        PUSH_VALID,
  input wire        POP_VALID
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  AST_WE_IN_DONE: assert property (PRODUCT_WE |-> DONE && CYCLES == 3'h2)
    else $error("product write outside a two-cycle commit");
  AST_PRODUCT_HELD: assert property (!PRODUCT_WE |-> $stable(PRODUCT))
    else $error("product pair changed without a write");
  AST_MUL_ZERO: assert property (PRODUCT_WE |-> STATUS[1] == (PRODUCT == 16'h0000))
    else $error("zero flag does not follow the product");
  AST_MUL_FLAGS_KEPT: assert property (PRODUCT_WE |-> STATUS[7:2] == $past(STATUS[7:2]))
    else $error("multiply touched flags other than zero and carry");
  AST_READY_BOUND: assert property (!READY |-> ##[1:3] READY)
    else $error("ready held low too long");
  AST_ISSUE_DONE: assert property ($fell(READY) |-> ##[1:4] DONE)
    else $error("multi-cycle operation did not commit in time");
  AST_PUSH_IN_DONE: assert property (PUSH_VALID |-> DONE && (CYCLES == 3'h3 || CYCLES == 3'h4))
    else $error("push strobe outside an invoke commit");
  AST_POP_FOUR: assert property (POP_VALID |-> DONE && CYCLES == 3'h4 && STATUS[6:0] == $past(STATUS[6:0]))
    else $error("return commit has wrong cost or flags");
  AST_SIGN_FLAG: assert property (STATUS[4] == (STATUS[3] ^ STATUS[2]))
    else $error("sign flag differs from negative xor overflow");
  AST_FLOW_FLAGS_KEPT: assert property (DONE && CYCLES != 3'h1 && !PRODUCT_WE && !POP_VALID |-> $stable(STATUS))
    else $error("flow operation changed the status register");
endmodule // mfcu_core_sva

bind mfcu_core mfcu_core_sva u_sva (
  .MCLK(MCLK), .RSTN(RSTN), .READY(READY), .DONE(DONE), .CYCLES(CYCLES), .STATUS(STATUS),
  .PRODUCT(PRODUCT), .PRODUCT_WE(PRODUCT_WE), .PUSH_VALID(PUSH_VALID), .POP_VALID(POP_VALID)
);

// ### sim/tb.sv
// tb.sv: self-checking bench for the multiply and program-flow executor
// assumes: the bench plays decoder and stack unit; one operation in flight at a time, except t_b2b, which issues a branch on a compare's commit edge
`timescale 1ns/100ps
`include "mfcu_defines.vh"

module tb;
  logic        MCLK = 1'b0;
  logic        RSTN = 1'b0;
  logic        ISSUE = 1'b0;
  logic [4:0]  OP = 5'h00;
  logic [7:0]  RD_VAL = 8'h00;
  logic [7:0]  RR_VAL = 8'h00;
  logic [2:0]  BIT_SEL = 3'h0;
  logic [7:0]  IO_VAL = 8'h00;
  logic [11:0] OFFSET = 12'h000;
  logic [15:0] TARGET = 16'h0000;
  logic [15:0] Z_PTR = 16'h0000;
  logic        NEXT_TWO_WORD = 1'b0;
  logic [15:0] STACK_TOP = 16'h0000;
  wire         READY, DONE, PRODUCT_WE, PUSH_VALID, POP_VALID;
  wire  [2:0]  CYCLES;
  wire  [15:0] PC, PRODUCT, PUSH_ADDR;
  wire  [7:0]  STATUS;
  logic [15:0] pc = 16'h0000;
  logic [7:0]  st = 8'h00;
  int          n_mismatch = 0;
  int          comparisons = 0;

  always #10 MCLK = ~MCLK;

  mfcu_core #(.PCW(16)) dut (
    .MCLK(MCLK), .RSTN(RSTN), .ISSUE(ISSUE), .OP(OP), .RD_VAL(RD_VAL), .RR_VAL(RR_VAL), .BIT_SEL(BIT_SEL),
    .IO_VAL(IO_VAL), .OFFSET(OFFSET), .TARGET(TARGET), .Z_PTR(Z_PTR), .NEXT_TWO_WORD(NEXT_TWO_WORD),
    .STACK_TOP(STACK_TOP), .READY(READY), .DONE(DONE), .CYCLES(CYCLES), .PC(PC), .STATUS(STATUS),
    .PRODUCT(PRODUCT), .PRODUCT_WE(PRODUCT_WE), .PUSH_VALID(PUSH_VALID), .PUSH_ADDR(PUSH_ADDR),
    .POP_VALID(POP_VALID)
  );

  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [16:0] s, input logic [16:0] e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // issue one operation, count edges up to its commit and check cost, pc and flags
  task automatic go(input logic [4:0] op, input int n, input logic [15:0] npc);
    int k;
    k = 0;
    @(posedge MCLK);
    #1;
    OP = op;
    ISSUE = 1'b1;
    @(posedge MCLK);
    #1;
    ISSUE = 1'b0;
    while (DONE !== 1'b1 && k < 8) begin
      @(posedge MCLK);
      #1;
      k++;
    end
    if (k == 8) begin
      n_mismatch++;
      end_of_test;
    end else begin
      chk(17'(k), 17'(n));
      chk({14'h0, CYCLES}, 17'(n));
      chk({1'b0, PC}, {1'b0, npc});
      chk({9'h0, STATUS}, {9'h0, st});
      pc = npc;
    end
  endtask

  task automatic t_mul;
    logic [15:0] a, b, p, r;
    logic [7:0]  x [3] = '{8'h80, 8'h7f, 8'h00};
    logic [7:0]  y [3] = '{8'hff, 8'h81, 8'h55};
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 3; j++) begin
        RD_VAL = x[j];
        RR_VAL = y[j];
        a = (i % 3 != 0) ? {{8{x[j][7]}}, x[j]} : {8'h00, x[j]};
        b = (i % 3 == 1) ? {{8{y[j][7]}}, y[j]} : {8'h00, y[j]};
        p = a * b;
        r = (i >= 3) ? {p[14:0], 1'b0} : p;
        st[1:0] = {r == 16'h0000, p[15]};
        go(5'(i), 2, pc + 16'h0001);
        chk({PRODUCT_WE, PRODUCT}, {1'b1, r});
      end
    end
  endtask

  task automatic t_cmp(input logic [4:0] op, input logic [7:0] d, input logic [7:0] k);
    logic [8:0] r;
    logic [4:0] h;
    logic       c;
    logic       cb;
    cb = op == `MFCU_OP_COMPARE_WITH_BORROW;
    c = cb & st[0];
    r = {1'b0, d} - {1'b0, k} - 9'(c);
    h = {1'b0, d[3:0]} - {1'b0, k[3:0]} - 5'(c);
    st[5] = h[4];
    st[3] = (d[7] & ~k[7] & ~r[7]) | (~d[7] & k[7] & r[7]);
    st[2] = r[7];
    st[4] = st[3] ^ st[2];
    st[1] = (r[7:0] == 8'h00) & (~cb | st[1]);
    st[0] = r[8];
    RD_VAL = d;
    RR_VAL = k;
    go(op, 1, pc + 16'h0001);
  endtask

  // every flag, both polarities; named branches are these selects
  task automatic t_br;
    logic       t;
    logic [4:0] o;
    OFFSET = 12'hffd;
    for (int s = 0; s < 8; s++) begin
      for (int v = 0; v < 2; v++) begin
        BIT_SEL = 3'(s);
        t = st[s] == v[0];
        o = v[0] ? `MFCU_OP_BRANCH_STATUS_BIT_SET : `MFCU_OP_BRANCH_STATUS_BIT_CLEAR;
        go(o, t ? 2 : 1, t ? pc - 16'h0002 : pc + 16'h0001);
      end
    end
  endtask

  task automatic t_skip;
    logic [4:0] ops [5] = '{`MFCU_OP_COMPARE_SKIP_EQUAL, `MFCU_OP_SKIP_REGISTER_BIT_CLEAR,
                            `MFCU_OP_SKIP_REGISTER_BIT_SET, `MFCU_OP_SKIP_IO_BIT_CLEAR, `MFCU_OP_SKIP_IO_BIT_SET};
    logic       sk;
    int         n;
    RD_VAL = 8'h5a;
    IO_VAL = 8'ha5;
    foreach (ops[i]) begin
      for (int b = 0; b < 8; b++) begin
        RR_VAL = b[1] ? 8'h5a : 8'h3c;
        BIT_SEL = 3'(b);
        NEXT_TWO_WORD = b[2];
        case (i)
          0: sk = RD_VAL == RR_VAL;
          1: sk = ~RR_VAL[b];
          2: sk = RR_VAL[b];
          3: sk = ~IO_VAL[b];
          default: sk = IO_VAL[b];
        endcase
        n = sk ? (b[2] ? 3 : 2) : 1;
        go(ops[i], n, pc + 16'(n));
      end
    end
  endtask

  task automatic t_flow;
    OFFSET = 12'h010;
    go(`MFCU_OP_RELATIVE_JUMP, 2, pc + 16'h0011);
    Z_PTR = 16'h1234;
    go(`MFCU_OP_POINTER_JUMP, 2, 16'h1234);
    TARGET = 16'h0400;
    go(`MFCU_OP_ABSOLUTE_JUMP, 3, 16'h0400);
    OFFSET = 12'hff0;
    go(`MFCU_OP_RELATIVE_INVOKE, 3, 16'h03f1);
    chk({PUSH_VALID, PUSH_ADDR}, {1'b1, 16'h0401});
    Z_PTR = 16'h2222;
    go(`MFCU_OP_POINTER_INVOKE, 3, 16'h2222);
    chk({PUSH_VALID, PUSH_ADDR}, {1'b1, 16'h03f2});
    TARGET = 16'h3000;
    go(`MFCU_OP_ABSOLUTE_INVOKE, 4, 16'h3000);
    chk({PUSH_VALID, PUSH_ADDR}, {1'b1, 16'h2224});
    STACK_TOP = 16'h0abc;
    go(`MFCU_OP_POP_PROGRAM_COUNTER, 4, 16'h0abc);
    chk({16'h0, POP_VALID}, 17'h00001);
    STACK_TOP = 16'h0def;
    st[7] = 1'b1;
    go(`MFCU_OP_INTERRUPT_EXIT_POP, 4, 16'h0def);
    go(`MFCU_OP_ADVANCE, 1, 16'h0df0);
  endtask

  // a branch issued on the commit edge of a compare must branch on the freshly computed zero flag
  task automatic t_b2b;
    int k;
    RD_VAL = 8'h33;
    RR_VAL = 8'h33;
    BIT_SEL = `MFCU_FLAG_Z;
    OFFSET = 12'h004;
    st[5:0] = 6'h02;
    @(posedge MCLK);
    #1;
    OP = `MFCU_OP_COMPARE_REGS;
    ISSUE = 1'b1;
    @(posedge MCLK);
    #1;
    OP = `MFCU_OP_BRANCH_STATUS_BIT_SET;
    @(posedge MCLK);
    #1;
    ISSUE = 1'b0;
    chk({DONE, PC}, {1'b1, pc + 16'h0001});
    chk({READY, 8'h00, STATUS}, {1'b0, 8'h00, st});
    @(posedge MCLK);
    #1;
    k = 1;
    while (DONE !== 1'b1 && k < 8) begin
      @(posedge MCLK);
      #1;
      k++;
    end
    if (k == 8) begin
      n_mismatch++;
      end_of_test;
    end else begin
      chk(17'(k), 17'h00002);
      chk({1'b0, PC}, {1'b0, pc + 16'h0006});
      pc = pc + 16'h0006;
    end
  endtask

  initial begin
    repeat (20) @(posedge MCLK);
    #1;
    RSTN = 1'b1;
    chk({READY, PC}, 17'h10000);
    t_mul;
    t_cmp(`MFCU_OP_COMPARE_REGS, 8'h10, 8'h20);
    t_br;
    t_cmp(`MFCU_OP_COMPARE_WITH_BORROW, 8'h20, 8'h1f);
    t_br;
    t_cmp(`MFCU_OP_COMPARE_IMMEDIATE, 8'h7f, 8'h80);
    t_br;
    t_cmp(`MFCU_OP_COMPARE_IMMEDIATE, 8'h05, 8'h05);
    t_skip;
    t_flow;
    t_b2b;
    t_br;
    end_of_test;
  end
endmodule // tb
